//--- src/sbw_watch.sv
// Contract
// RQ1: count seconds through leap year, all displayable
// RQ2: timebase is a 32768 Hz crystal
// RQ3: option input picks 12h AM/PM or 24h HR
// RQ4: calendar order month-date-day or date-month-day
// RQ5: normal view shows hours minutes seconds
// RQ6: held button outside set shows calendar
// RQ7: calendar stays two seconds after release
// RQ8: five quick pushes enter month set
// RQ9: set modes step month date day hour minute
// RQ10: six idle seconds advance set mode
// RQ11: one push adds exactly one count
// RQ12: held button repeats at one hertz
// RQ13: minute set timeout returns to normal
// RQ14: after minute set, next push zeroes seconds
// RQ15: count test input speeds up counting
// RQ16: display test lights every segment
// RQ17: display test plus button master clears
// RQ18: leap counter 1-4, February 29 at 4
// RQ19: leap advances when month wraps to 1
// RQ20: leading zero of hour date month blanked
// RQ21: crystal divided by 2^15 gives seconds
// RQ22: date wraps by month length, weekday seven
`timescale 1ns/1ps
module sbw_watch #(
    parameter int SEC_DIV = sbw_pkg::SEC_DIV_DEF
) (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_BUTTON,
    input wire logic I_DISPLAY_TEST,
    input wire logic I_COUNT_TEST,
    input wire logic I_HOUR24,
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    output logic [23:0] O_DIGITS,
    output logic [1:0] O_SYMBOL,
    output logic O_COLON,
    output logic O_LAMP_TEST
);
    import sbw_pkg::*;

    if (SEC_DIV < 2 || SEC_DIV > 1_000_000 || XTAL_HZ >= CLK_HZ) begin : g_bad_param
        $error("sbw_watch: SEC_DIV or clock rates out of range");
    end

    localparam logic [31:0] T_SEC = 32'(REPEAT_S * SEC_DIV);
    localparam logic [31:0] T_CAL = 32'(CAL_HOLD_S * SEC_DIV);
    localparam logic [31:0] T_GAP = 32'(PUSH_GAP_S * SEC_DIV);
    localparam logic [31:0] T_IDLE = 32'(SET_IDLE_S * SEC_DIV);

    function automatic logic [7:0] to_bcd(input logic [5:0] v);
        logic [3:0] tens;
        logic [5:0] r;
        tens = 4'h0;
        r = v;
        for (int i = 0; i < 6; i++) begin
            if (r >= 6'd10) begin
                r = r - 6'd10;
                tens = tens + 4'h1;
            end
        end
        return {tens, r[3:0]};
    endfunction

    function automatic logic [7:0] blank_lead(input logic [7:0] b);
        return (b[7:4] == 4'h0) ? {DIG_BLANK, b[3:0]} : b; // [RQ20]
    endfunction

    function automatic logic [4:0] days_in(input logic [3:0] m, input logic [2:0] lp);
        case (m)
            4'h2: days_in = (lp == LAST_LEAP) ? 5'd29 : 5'd28; // [RQ18]
            4'h4, 4'h6, 4'h9, 4'hB: days_in = 5'd30;
            default: days_in = 5'd31; // [RQ22]
        endcase
    endfunction

    // timebase and bus
    logic [26:0] acc_reg, acc_next;
    logic xtal_tick_reg, xtal_tick_next;
    logic [31:0] presc_reg, presc_next;
    logic sec_tick_reg, sec_tick_next;
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wait_reg, wait_next;
    // watch state
    sbw_mode_t mode_reg, mode_next;
    logic [5:0] sec_reg, sec_next, min_reg, min_next;
    logic [4:0] hour_reg, hour_next, date_reg, date_next;
    logic [3:0] month_reg, month_next;
    logic [2:0] wday_reg, wday_next, leap_reg, leap_next, push_reg, push_next;
    logic [31:0] evt_reg, evt_next;
    logic btn_reg, cal_reg, cal_next, armed_reg, armed_next, hold_reg, hold_next;
    // display
    logic [23:0] digits_reg, digits_next;
    logic [1:0] sym_reg, sym_next;
    logic colon_reg, colon_next, lamp_reg, lamp_next;

    logic press, release_evt, bus_req;
    assign press = I_BUTTON & ~btn_reg;
    assign release_evt = ~I_BUTTON & btn_reg;
    assign bus_req = I_AVS_READ | I_AVS_WRITE;

    always_comb begin
        logic [31:0] sum;
        sum = 32'(acc_reg) + 32'(XTAL_HZ);
        // fractional divider makes a 32768 Hz enable from the system clock
        xtal_tick_next = sum >= 32'(CLK_HZ); // [RQ2]
        acc_next = xtal_tick_next ? 27'(sum - 32'(CLK_HZ)) : 27'(sum);
        presc_next = presc_reg;
        sec_tick_next = 1'b0;
        if (xtal_tick_reg) begin
            presc_next = (presc_reg == 32'(SEC_DIV - 1)) ? 32'h0 : presc_reg + 32'h1; // [RQ21]
            sec_tick_next = I_COUNT_TEST || presc_reg == 32'(SEC_DIV - 1); // [RQ15]
        end
        // one wait cycle per access; data is ready when waitrequest drops
        wait_next = !(bus_req && wait_reg);
        ctrl_next = ctrl_reg;
        rdata_next = rdata_reg;
        if (bus_req && wait_reg && I_AVS_READ) begin
            case (I_AVS_ADDRESS)
                ADDR_TIME: rdata_next = {11'h0, hour_reg, 2'h0, min_reg, 2'h0, sec_reg}; // [RQ1]
                ADDR_DATE: rdata_next = {5'h0, leap_reg, 4'h0, month_reg, 5'h0, wday_reg,
                    3'h0, date_reg};
                ADDR_STATUS: rdata_next = {20'h0, push_reg, hold_reg, armed_reg, cal_reg,
                    3'h0, mode_reg};
                ADDR_CTRL: rdata_next = ctrl_reg;
                default: rdata_next = 32'h0;
            endcase
        end
        if (I_AVS_WRITE && !wait_reg && I_AVS_ADDRESS == ADDR_CTRL && I_AVS_BYTEENABLE[0]) begin
            ctrl_next = {31'h0, I_AVS_WRITEDATA[CTRL_RUN_BIT]};
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            acc_reg <= 27'h0;
            xtal_tick_reg <= 1'b0;
            presc_reg <= 32'h0;
            sec_tick_reg <= 1'b0;
            ctrl_reg <= CTRL_RESET;
            rdata_reg <= 32'h0;
            wait_reg <= 1'b1;
        end else begin
            acc_reg <= acc_next;
            xtal_tick_reg <= xtal_tick_next;
            presc_reg <= presc_next;
            sec_tick_reg <= sec_tick_next;
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
            wait_reg <= wait_next;
        end
    end

    always_comb begin
        logic bump;
        bump = 1'b0;
        mode_next = mode_reg;
        sec_next = sec_reg;
        min_next = min_reg;
        hour_next = hour_reg;
        date_next = date_reg;
        month_next = month_reg;
        wday_next = wday_reg;
        leap_next = leap_reg;
        push_next = push_reg;
        cal_next = cal_reg;
        armed_next = armed_reg;
        hold_next = hold_reg;
        evt_next = (xtal_tick_reg && evt_reg < T_IDLE) ? evt_reg + 32'h1 : evt_reg;
        if (press || release_evt) begin
            evt_next = 32'h0;
        end
        if (sec_tick_reg && ctrl_reg[CTRL_RUN_BIT] && !hold_reg) begin // [RQ1]
            sec_next = sec_reg + 6'h1;
            if (sec_reg == LAST_SEC) begin
                sec_next = INIT_SEC;
                min_next = min_reg + 6'h1;
                if (min_reg == LAST_SEC) begin
                    min_next = INIT_MIN;
                    hour_next = hour_reg + 5'h1;
                    if (hour_reg == LAST_HOUR) begin
                        hour_next = INIT_HOUR;
                        wday_next = (wday_reg == LAST_WDAY) ? INIT_WDAY : wday_reg + 3'h1;
                        date_next = date_reg + 5'h1;
                        if (date_reg >= days_in(month_reg, leap_reg)) begin // [RQ22]
                            date_next = INIT_DATE;
                            month_next = month_reg + 4'h1;
                            if (month_reg == LAST_MONTH) begin
                                month_next = INIT_MONTH;
                                leap_next = (leap_reg == LAST_LEAP) ? INIT_LEAP
                                    : leap_reg + 3'h1; // [RQ19]
                            end
                        end
                    end
                end
            end
        end
        case (mode_reg)
            SBW_NORMAL: begin
                if (press && armed_reg) begin
                    sec_next = INIT_SEC; // [RQ14]
                    hold_next = 1'b1;
                    armed_next = 1'b0;
                end else if (press) begin
                    cal_next = 1'b1; // [RQ6]
                    push_next = (push_reg == 3'h0 || evt_reg >= T_GAP) ? 3'h1
                        : (push_reg == PUSHES_TO_SET) ? push_reg : push_reg + 3'h1; // [RQ8]
                end
                if (release_evt) begin
                    hold_next = 1'b0;
                    if (push_reg == PUSHES_TO_SET) begin
                        mode_next = SBW_SET_MONTH; // [RQ8]
                        push_next = 3'h0;
                        cal_next = 1'b0;
                    end
                end
                if (!I_BUTTON && !btn_reg && evt_reg >= T_CAL) begin
                    cal_next = 1'b0; // [RQ7]
                end
            end
            default: begin
                bump = press; // [RQ11]
                if (I_BUTTON && btn_reg && xtal_tick_reg && evt_reg >= T_SEC - 32'h1) begin
                    bump = 1'b1; // [RQ12]
                    evt_next = 32'h0;
                end
                if (press && mode_reg == SBW_SET_MIN) begin
                    armed_next = 1'b1;
                end
                if (!I_BUTTON && !btn_reg && evt_reg >= T_IDLE) begin // [RQ10]
                    evt_next = 32'h0;
                    case (mode_reg)
                        SBW_SET_MONTH: mode_next = SBW_SET_DATE; // [RQ9]
                        SBW_SET_DATE: mode_next = SBW_SET_DAY;
                        SBW_SET_DAY: mode_next = SBW_SET_HOUR;
                        SBW_SET_HOUR: mode_next = SBW_SET_MIN;
                        default: mode_next = SBW_NORMAL; // [RQ13]
                    endcase
                end
            end
        endcase
        if (bump) begin
            case (mode_reg)
                SBW_SET_MONTH: begin
                    month_next = (month_reg == LAST_MONTH) ? INIT_MONTH : month_reg + 4'h1;
                    if (month_reg == LAST_MONTH) begin
                        leap_next = (leap_reg == LAST_LEAP) ? INIT_LEAP : leap_reg + 3'h1;
                    end
                end
                SBW_SET_DATE: date_next = (date_reg >= days_in(month_reg, leap_reg))
                    ? INIT_DATE : date_reg + 5'h1;
                SBW_SET_DAY: wday_next = (wday_reg == LAST_WDAY) ? INIT_WDAY : wday_reg + 3'h1;
                SBW_SET_HOUR: hour_next = (hour_reg == LAST_HOUR) ? INIT_HOUR : hour_reg + 5'h1;
                default: min_next = (min_reg == LAST_SEC) ? INIT_MIN : min_reg + 6'h1;
            endcase
        end
        // a month change may leave the date past the new month's end
        if (date_next > days_in(month_next, leap_next)) begin
            date_next = days_in(month_next, leap_next);
        end
        if (I_DISPLAY_TEST && I_BUTTON) begin // [RQ17]
            mode_next = SBW_NORMAL;
            sec_next = INIT_SEC;
            min_next = INIT_MIN;
            hour_next = INIT_HOUR;
            date_next = INIT_DATE;
            month_next = INIT_MONTH;
            wday_next = INIT_WDAY;
            leap_next = INIT_LEAP;
            push_next = 3'h0;
            cal_next = 1'b0;
            armed_next = 1'b0;
            hold_next = 1'b0;
            evt_next = 32'h0;
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            mode_reg <= SBW_NORMAL;
            sec_reg <= INIT_SEC;
            min_reg <= INIT_MIN;
            hour_reg <= INIT_HOUR;
            date_reg <= INIT_DATE;
            month_reg <= INIT_MONTH;
            wday_reg <= INIT_WDAY;
            leap_reg <= INIT_LEAP;
            push_reg <= 3'h0;
            evt_reg <= 32'h0;
            btn_reg <= 1'b0;
            cal_reg <= 1'b0;
            armed_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            sec_reg <= sec_next;
            min_reg <= min_next;
            hour_reg <= hour_next;
            date_reg <= date_next;
            month_reg <= month_next;
            wday_reg <= wday_next;
            leap_reg <= leap_next;
            push_reg <= push_next;
            evt_reg <= evt_next;
            btn_reg <= I_BUTTON;
            cal_reg <= cal_next;
            armed_reg <= armed_next;
            hold_reg <= hold_next;
        end
    end

    always_comb begin
        logic [4:0] h_disp;
        logic [7:0] hb, mb, sb, mob, db;
        logic [15:0] day_pair;
        logic flash;
        h_disp = hour_reg;
        if (!I_HOUR24) begin
            h_disp = (hour_reg >= HOURS_HALF) ? hour_reg - HOURS_HALF : hour_reg;
            h_disp = (h_disp == 5'h00) ? HOURS_HALF : h_disp;
        end
        hb = blank_lead(to_bcd({1'b0, h_disp}));
        mb = to_bcd(min_reg);
        sb = to_bcd(sec_reg);
        mob = blank_lead(to_bcd({2'h0, month_reg}));
        db = blank_lead(to_bcd({1'b0, date_reg}));
        day_pair = {DIG_BLANK, 1'b0, wday_reg, 8'h0};
        flash = presc_reg < 32'(SEC_DIV / 2);
        sym_next = I_HOUR24 ? SYM_HR : (hour_reg >= HOURS_HALF) ? SYM_PM : SYM_AM; // [RQ3]
        colon_next = 1'b0;
        case (mode_reg)
            SBW_SET_MONTH: begin
                digits_next = {mob, DIG_BLANK, DIG_BLANK, DIG_BLANK, 1'b0, leap_reg};
                colon_next = flash;
            end
            SBW_SET_DATE, SBW_SET_DAY: begin
                digits_next = I_HOUR24 ? {db, mob, day_pair[15:8]} : {mob, db, day_pair[15:8]};
                colon_next = flash;
            end
            SBW_SET_HOUR, SBW_SET_MIN: begin
                digits_next = {hb, mb, sb};
                colon_next = flash;
            end
            default: begin
                if (cal_reg) begin
                    // calendar order follows the hour option
                    digits_next = I_HOUR24 ? {db, mob, day_pair[15:8]}
                        : {mob, db, day_pair[15:8]}; // [RQ4]
                    colon_next = (push_reg == PUSHES_TO_SET) && btn_reg && flash;
                end else begin
                    digits_next = {hb, mb, sb}; // [RQ5]
                    colon_next = 1'b1;
                end
            end
        endcase
        lamp_next = I_DISPLAY_TEST;
        if (I_DISPLAY_TEST) begin
            digits_next = {6{DIG_ALL_ON}}; // [RQ16]
            colon_next = 1'b1;
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            digits_reg <= {6{DIG_BLANK}};
            sym_reg <= SYM_AM;
            colon_reg <= 1'b0;
            lamp_reg <= 1'b0;
        end else begin
            digits_reg <= digits_next;
            sym_reg <= sym_next;
            colon_reg <= colon_next;
            lamp_reg <= lamp_next;
        end
    end

    assign O_AVS_READDATA = rdata_reg;
    assign O_AVS_WAITREQUEST = wait_reg;
    assign O_DIGITS = digits_reg;
    assign O_SYMBOL = sym_reg;
    assign O_COLON = colon_reg;
    assign O_LAMP_TEST = lamp_reg;
endmodule // sbw_watch

//--- src/sbw_pkg.sv
package sbw_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int XTAL_HZ = 32768;
    localparam int SEC_DIV_DEF = 32768;
    localparam int CAL_HOLD_S = 2;
    localparam int PUSH_GAP_S = 2;
    localparam int SET_IDLE_S = 6;
    localparam int REPEAT_S = 1;
    localparam logic [2:0] PUSHES_TO_SET = 3'h5;

    localparam logic [3:0] ADDR_TIME = 4'h0;
    localparam logic [3:0] ADDR_DATE = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_CTRL = 4'hC;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    localparam logic [5:0] INIT_SEC = 6'h00;
    localparam logic [5:0] INIT_MIN = 6'h00;
    localparam logic [4:0] INIT_HOUR = 5'h00;
    localparam logic [4:0] INIT_DATE = 5'h01;
    localparam logic [3:0] INIT_MONTH = 4'h1;
    localparam logic [2:0] INIT_WDAY = 3'h1;
    localparam logic [2:0] INIT_LEAP = 3'h1;
    localparam logic [5:0] LAST_SEC = 6'h3B;
    localparam logic [4:0] LAST_HOUR = 5'h17;
    localparam logic [3:0] LAST_MONTH = 4'hC;
    localparam logic [2:0] LAST_WDAY = 3'h7;
    localparam logic [2:0] LAST_LEAP = 3'h4;
    localparam logic [3:0] FEB = 4'h2;
    localparam logic [4:0] HOURS_HALF = 5'h0C;

    localparam logic [3:0] DIG_BLANK = 4'hF;
    localparam logic [3:0] DIG_ALL_ON = 4'h8;
    localparam logic [1:0] SYM_AM = 2'h0;
    localparam logic [1:0] SYM_PM = 2'h1;
    localparam logic [1:0] SYM_HR = 2'h2;

    typedef enum logic [2:0] {
        SBW_NORMAL = 3'h0,
        SBW_SET_MONTH = 3'h1,
        SBW_SET_DATE = 3'h2,
        SBW_SET_DAY = 3'h3,
        SBW_SET_HOUR = 3'h4,
        SBW_SET_MIN = 3'h5
    } sbw_mode_t;
endpackage

//--- tb/sbw_watch_assertions.sv
`timescale 1ns/1ps
module sbw_watch_assertions (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_DISPLAY_TEST,
    input wire logic I_HOUR24,
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic [23:0] O_DIGITS,
    input wire logic [1:0] O_SYMBOL,
    input wire logic O_LAMP_TEST
);
    import sbw_pkg::*;
    logic [1:0] up_reg;
    logic [1:0] up_next;
    logic ok;
    logic rdv;
    // display checks wait out the registered path after reset
    always_comb begin
        up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
    end
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            up_reg <= 2'h0;
        end else begin
            up_reg <= up_next;
        end
    end
    assign ok = (up_reg == 2'h3);
    assign rdv = I_AVS_READ && !O_AVS_WAITREQUEST;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    sequence s_taken; (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST; endsequence
    sequence s_answer; !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST; endsequence
    sequence s_dt3; I_DISPLAY_TEST && $past(I_DISPLAY_TEST) && $past(I_DISPLAY_TEST, 2); endsequence
    sequence s_nodt3; !I_DISPLAY_TEST && !$past(I_DISPLAY_TEST) && !$past(I_DISPLAY_TEST, 2);
    endsequence
    property p_answer; s_taken |=> s_answer; endproperty
    a_answer: assert property (p_answer) else $error("bus answer not one cycle");
    property p_cause; $fell(O_AVS_WAITREQUEST) |-> $past(I_AVS_READ || I_AVS_WRITE); endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_unmapped; rdv && I_AVS_ADDRESS[1:0] != 2'h0 |-> O_AVS_READDATA == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_time; rdv && I_AVS_ADDRESS == ADDR_TIME |-> O_AVS_READDATA[20:16] <= LAST_HOUR
        && O_AVS_READDATA[13:8] <= LAST_SEC && O_AVS_READDATA[5:0] <= LAST_SEC; endproperty
    a_time: assert property (p_time) else $error("time field out of range");
    property p_date; rdv && I_AVS_ADDRESS == ADDR_DATE |-> O_AVS_READDATA[26:24] inside
        {[3'h1:3'h4]} && O_AVS_READDATA[19:16] inside {[4'h1:4'hC]} && O_AVS_READDATA[10:8]
        inside {[3'h1:3'h7]} && O_AVS_READDATA[4:0] != 5'h0; endproperty
    a_date: assert property (p_date) else $error("date field out of range");
    property p_mode; rdv && I_AVS_ADDRESS == ADDR_STATUS |-> O_AVS_READDATA[2:0] <= 3'h5;
    endproperty
    a_mode: assert property (p_mode) else $error("mode out of range");
    property p_sym24; ok && I_HOUR24 && $past(I_HOUR24) ##0 s_nodt3 |-> O_SYMBOL == SYM_HR;
    endproperty
    a_sym24: assert property (p_sym24) else $error("24h symbol wrong");
    property p_sym12; ok && !I_HOUR24 && !$past(I_HOUR24) ##0 s_nodt3 |-> O_SYMBOL <= SYM_PM;
    endproperty
    a_sym12: assert property (p_sym12) else $error("12h symbol wrong");
    property p_all_on; ok ##0 s_dt3 |-> O_DIGITS == {6{DIG_ALL_ON}}; endproperty
    a_all_on: assert property (p_all_on) else $error("test digits not all on");
    property p_lamp; $rose(I_DISPLAY_TEST) |=> O_LAMP_TEST; endproperty
    a_lamp: assert property (p_lamp) else $error("lamp test late");
    property p_lead; ok ##0 s_nodt3 |-> O_DIGITS[23:20] != 4'h0; endproperty
    a_lead: assert property (p_lead) else $error("leading zero shown");
endmodule // sbw_watch_assertions
bind sbw_watch sbw_watch_assertions u_chk (.I_MCLK(I_MCLK), .I_RST(I_RST),
    .I_DISPLAY_TEST(I_DISPLAY_TEST), .I_HOUR24(I_HOUR24), .I_AVS_ADDRESS(I_AVS_ADDRESS),
    .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_DIGITS(O_DIGITS), .O_SYMBOL(O_SYMBOL),
    .O_LAMP_TEST(O_LAMP_TEST));

//--- tb/sbw_wearer.sv
`timescale 1ns/1ps
module sbw_wearer (
    input wire logic i_clk,
    output logic o_button
);
    initial o_button = 1'b0;
    task automatic down;
        @(posedge i_clk);
        o_button <= 1'b1;
    endtask
    task automatic up;
        @(posedge i_clk);
        o_button <= 1'b0;
    endtask
    // gap stays well under two seconds so pushes chain
    task automatic push(input int hold, input int gap);
        down;
        repeat (hold) @(posedge i_clk);
        up;
        repeat (gap) @(posedge i_clk);
    endtask
endmodule // sbw_wearer

//--- tb/sbw_watch_tb.sv
`timescale 1ns/1ps
module sbw_watch_tb;
    import sbw_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic btn;
    logic dt = 1'b0;
    logic ct = 1'b0;
    logic h24 = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic [23:0] digits;
    logic [1:0] symbol;
    logic lamp;
    logic colon;
    logic [31:0] t0;
    logic [31:0] t1;
    int miscompares = 0;
    int n_compared = 0;
    always #5 mclk = ~mclk;
    sbw_wearer u_w (.i_clk(mclk), .o_button(btn));
    // short second so the run fits; every wait below counts mclk cycles, not seconds
    sbw_watch #(.SEC_DIV(4)) uut (.I_MCLK(mclk), .I_RST(rst), .I_BUTTON(btn),
        .I_DISPLAY_TEST(dt), .I_COUNT_TEST(ct), .I_HOUR24(h24), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd_s), .I_AVS_WRITE(wr_s), .I_AVS_WRITEDATA(wdata),
        .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
        .O_DIGITS(digits), .O_SYMBOL(symbol), .O_COLON(colon), .O_LAMP_TEST(lamp));
    task automatic complete_run;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        addr <= a;
        wdata <= wd;
        rd_s <= ~wr;
        wr_s <= wr;
        do begin
            @(posedge mclk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (n >= 50) begin
            miscompares++;
            $display("[ERR] %0t bus answer missing", $time);
        end
        d = rdata;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask
    task automatic rdx(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk(d & m, e);
    endtask
    initial begin
        repeat (95000) @(posedge mclk);
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run;
    end
    initial begin
        w(2);
        rst <= 1'b0;
        rdx(ADDR_TIME, 32'hFFFF_FFFF, 32'h0);
        rdx(ADDR_DATE, 32'hFFFF_FFFF, 32'h0101_0101);
        rdx(ADDR_CTRL, 32'h1, CTRL_RESET);
        rdx(4'h2, 32'hFFFF_FFFF, 32'h0);
        rdx(ADDR_STATUS, 32'hFFFF_FFFF, 32'h0);
        chk({8'h0, digits}, 32'h0012_0000);
        chk({30'h0, symbol}, {30'h0, SYM_AM});
        chk({31'h0, colon}, 32'h1);
        h24 <= 1'b1;
        w(4);
        chk({8'h0, digits}, 32'h00F0_0000);
        chk({30'h0, symbol}, {30'h0, SYM_HR});
        h24 <= 1'b0;
        dt <= 1'b1;
        w(4);
        chk({8'h0, digits}, 32'h0088_8888);
        chk({31'h0, lamp}, 32'h1);
        dt <= 1'b0;
        w(4);
        u_w.down;
        w(4);
        chk({8'h0, digits}, 32'h00F1_F1F1);
        rdx(ADDR_STATUS, 32'h40, 32'h40);
        u_w.up;
        w(20000);
        chk({8'h0, digits}, 32'h00F1_F1F1);
        w(6000);
        chk({24'h0, digits[23:16]}, 32'h12);
        ct <= 1'b1;
        bus(1'b1, ADDR_CTRL, 32'h0, t0);
        bus(1'b0, ADDR_TIME, 32'h0, t0);
        w(7000);
        rdx(ADDR_TIME, 32'hFFFF_FFFF, t0);
        bus(1'b1, ADDR_CTRL, 32'h1, t0);
        bus(1'b0, ADDR_TIME, 32'h0, t0);
        w(12400);
        bus(1'b0, ADDR_TIME, 32'h0, t1);
        chk({31'h0, (t1[5:0] - t0[5:0]) >= 6'h3}, 32'h1);
        ct <= 1'b0;
        repeat (5) u_w.push(200, 200);
        rdx(ADDR_STATUS, 32'h7, 32'h1);
        u_w.push(100, 20);
        rdx(ADDR_DATE, 32'h000F_0000, 32'h0002_0000);
        chk({8'h0, digits}, 32'h00F2_FFF1);
        u_w.down;
        w(30500);
        u_w.up;
        w(5);
        rdx(ADDR_DATE, 32'h000F_0000, 32'h0005_0000);
        rdx(ADDR_STATUS, 32'h7, 32'h1);
        dt <= 1'b1;
        w(2);
        u_w.down;
        w(5);
        u_w.up;
        w(2);
        dt <= 1'b0;
        w(3);
        rdx(ADDR_DATE, 32'h070F_071F, 32'h0101_0101);
        rdx(ADDR_TIME, 32'h001F_3F00, 32'h0);
        rdx(ADDR_STATUS, 32'h7, 32'h0);
        complete_run;
    end
endmodule // sbw_watch_tb
